// [rtl/oag_defines.vh]
// Constants for the operand address generator.
// Assumes inclusion by the decode and address modules of that block.
`ifndef OAG_DEFINES_VH
`define OAG_DEFINES_VH

// ----------------------------------------------------------------------
// Operand sizes
// ----------------------------------------------------------------------
`define OAG_SZ_BYTE 2'h0
`define OAG_SZ_WORD 2'h1
`define OAG_SZ_LONG 2'h2

// ----------------------------------------------------------------------
// Addressing modes
// ----------------------------------------------------------------------
`define OAG_M_DIRECT 4'h0
`define OAG_M_IND 4'h1
`define OAG_M_POSTINC 4'h2
`define OAG_M_PREDEC 4'h3
`define OAG_M_DISP4 4'h4
`define OAG_M_IDX 4'h5
`define OAG_M_GBDISP 4'h6
`define OAG_M_GBIDX 4'h7
`define OAG_M_PCDISP 4'h8
`define OAG_M_BR8 4'h9
`define OAG_M_BR12 4'hA
`define OAG_M_BRREG 4'hB
`define OAG_M_MAC 4'hC

// ----------------------------------------------------------------------
// Register field formats
// ----------------------------------------------------------------------
`define OAG_F_NM 3'h0
`define OAG_F_M 3'h1
`define OAG_F_MD 3'h2
`define OAG_F_ND4 3'h3
`define OAG_F_NI 3'h4

// ----------------------------------------------------------------------
// Immediate kinds
// ----------------------------------------------------------------------
`define OAG_I_LOGIC 2'h0
`define OAG_I_ARITH 2'h1
`define OAG_I_TRAP 2'h2

// Masks and field positions
`define OAG_LONG_PC_MASK 32'hFFFF_FFFC
`define OAG_REG_ZERO 4'h0
`define OAG_FLD_HI 11
`define OAG_FLD_MID 7
`define OAG_FLD_LO 3

`endif

// [rtl/oag_field_decode.v]
// Register, displacement and immediate field extraction.
// Assumes the pipeline supplies the 16-bit word and its format code.
`timescale 1ns/10ps
`include "oag_defines.vh"

module oag_field_decode (
	// Instruction
	input wire [15:0] instr,
	input wire [2:0] fmt,
	input wire [1:0] imm_kind,
	// Fields
	output reg [3:0] dst_reg,
	output reg [3:0] src_reg,
	output wire [3:0] disp4,
	output wire [7:0] disp8,
	output wire [11:0] disp12,
	output reg [31:0] imm_ext
);

	assign disp4 = instr[`OAG_FLD_LO:0];
	assign disp8 = instr[`OAG_FLD_MID:0];
	assign disp12 = instr[`OAG_FLD_HI:0];

	// Register numbers per format; 0000..1111 map straight to R0..R15
	always @* begin
		dst_reg = instr[11:8];
		src_reg = instr[7:4];
		case (fmt)
		`OAG_F_NM: begin
			dst_reg = instr[11:8];
			src_reg = instr[7:4];
		end
		`OAG_F_M: begin
			src_reg = instr[11:8];
			dst_reg = instr[11:8];
		end
		`OAG_F_MD: begin
			src_reg = instr[7:4];
			dst_reg = `OAG_REG_ZERO;
		end
		`OAG_F_ND4: begin
			dst_reg = instr[7:4];
			src_reg = `OAG_REG_ZERO;
		end
		`OAG_F_NI: begin
			dst_reg = instr[11:8];
			src_reg = `OAG_REG_ZERO;
		end
		default: begin
			dst_reg = instr[11:8];
			src_reg = instr[7:4];
		end
		endcase
	end

	// Immediate extension by instruction class
	always @* begin
		case (imm_kind)
		`OAG_I_ARITH: imm_ext = {{24{instr[7]}}, instr[7:0]};
		`OAG_I_TRAP: imm_ext = {22'h00_0000, instr[7:0], 2'h0};
		default: imm_ext = {24'h00_0000, instr[7:0]};
		endcase
	end

endmodule

// [rtl/oag_scale.v]
// Displacement scaler: zero-extended 8-bit value times 1, 2 or 4.
// Assumes the size code is one of byte, word or longword.
`timescale 1ns/10ps
`include "oag_defines.vh"

module oag_scale (
	// Input
	input wire [7:0] disp,
	input wire [1:0] size,
	// Result
	output reg [31:0] scaled
);

	// Zero extension before the shift keeps the result unsigned
	always @* begin
		case (size)
		`OAG_SZ_WORD: scaled = {23'h00_0000, disp, 1'h0};
		`OAG_SZ_LONG: scaled = {22'h00_0000, disp, 2'h0};
		default: scaled = {24'h00_0000, disp};
		endcase
	end

endmodule

// [rtl/oag_top.v]
// Operand address generator: decodes fields, forms effective addresses.
// Assumes the pipeline presents one instruction per valid cycle along
// with register contents it has already read for the decoded numbers.
// Size code 3 steps and scales as a byte; unused mode codes are no-ops.
`timescale 1ns/10ps
`include "oag_defines.vh"

module oag_top (
	// Clock and reset
	input wire ref_clk,
	input wire resetn,
	// Request from decode
	input wire req_valid,
	input wire [15:0] instr,
	input wire [3:0] mode,
	input wire [2:0] fmt,
	input wire [1:0] size,
	input wire [1:0] imm_kind,
	// Register contents read by the pipeline
	input wire [31:0] src_val,
	input wire [31:0] dst_val,
	input wire [31:0] r0_val,
	input wire [31:0] global_base_pointer,
	input wire [31:0] pc,
	// Decoded register numbers (combinational, for the register read)
	output wire [3:0] dst_reg,
	output wire [3:0] src_reg,
	// Results, registered
	output reg out_valid,
	output reg addr_valid,
	output reg [31:0] addr,
	output reg [31:0] addr2,
	output reg addr2_valid,
	output reg [31:0] operand,
	output reg [31:0] imm_value,
	output reg [31:0] branch_target,
	output reg branch_valid,
	output reg wb_en,
	output reg [3:0] wb_reg,
	output reg [31:0] wb_value,
	output reg wb2_en,
	output reg [3:0] wb2_reg,
	output reg [31:0] wb2_value,
	output reg accum_write,
	output reg addr_error
);

	// ------------------------------------------------------------------
	// Decoded fields and scaled displacements
	// ------------------------------------------------------------------
	wire [3:0] disp4;
	wire [7:0] disp8;
	wire [11:0] disp12;
	wire [31:0] imm_ext;
	wire [31:0] scaled4;
	wire [31:0] scaled8;

	// Combinational intermediates and next values of the result registers
	reg [31:0] step;
	reg [31:0] base;
	reg [31:0] next_addr;
	reg [31:0] next_target;
	reg next_addr_valid;
	reg next_branch_valid;
	reg next_wb_en;
	reg [31:0] next_wb_value;
	reg [3:0] next_wb_reg;
	reg next_wb2_en;
	reg next_addr2_valid;
	reg next_accum;
	reg [31:0] next_operand;
	reg next_misalign;

	// ------------------------------------------------------------------
	// Field extraction and displacement scaling
	// ------------------------------------------------------------------
	oag_field_decode u_fields (
		.instr(instr),
		.fmt(fmt),
		.imm_kind(imm_kind),
		.dst_reg(dst_reg),
		.src_reg(src_reg),
		.disp4(disp4),
		.disp8(disp8),
		.disp12(disp12),
		.imm_ext(imm_ext)
	);

	// Short displacement reuses the same scaler after zero extension
	oag_scale u_scale4 (
		.disp({4'h0, disp4}),
		.size(size),
		.scaled(scaled4)
	);

	// Global base and longword PC-relative displacements share the 8-bit scaler
	oag_scale u_scale8 (
		.disp(disp8),
		.size(size),
		.scaled(scaled8)
	);

	// ------------------------------------------------------------------
	// Step size for increment and decrement
	// ------------------------------------------------------------------
	// Size code 3 falls to the byte step rather than leaving it unknown
	always @* begin
		case (size)
		`OAG_SZ_WORD: step = 32'h0000_0002;
		`OAG_SZ_LONG: step = 32'h0000_0004;
		default: step = 32'h0000_0001;
		endcase
	end

	// ------------------------------------------------------------------
	// Effective address per mode; 32-bit sums wrap naturally
	// ------------------------------------------------------------------
	// pc is the value the pipeline defines for PC-relative forms; any
	// fetch offset must be applied before it reaches this block
	always @* begin
		next_addr = 32'h0000_0000;
		next_target = 32'h0000_0000;
		next_addr_valid = 1'b0;
		next_branch_valid = 1'b0;
		next_wb_en = 1'b0;
		next_wb_reg = src_reg;
		next_wb_value = 32'h0000_0000;
		next_wb2_en = 1'b0;
		next_addr2_valid = 1'b0;
		next_accum = 1'b0;
		next_operand = 32'h0000_0000;
		base = 32'h0000_0000;
		case (mode)
		`OAG_M_DIRECT: begin
			next_operand = src_val;
		end
		`OAG_M_IND: begin
			next_addr = src_val;
			next_addr_valid = 1'b1;
		end
		`OAG_M_POSTINC: begin
			next_addr = src_val;
			next_addr_valid = 1'b1;
			next_wb_en = 1'b1;
			next_wb_reg = src_reg;
			next_wb_value = src_val + step;
		end
		`OAG_M_PREDEC: begin
			// Destination register is the one stepped down
			next_addr = dst_val - step;
			next_addr_valid = 1'b1;
			next_wb_en = 1'b1;
			next_wb_reg = dst_reg;
			next_wb_value = dst_val - step;
		end
		`OAG_M_DISP4: begin
			// Base is the register named by the displacement format
			base = (fmt == `OAG_F_ND4) ? dst_val : src_val;
			next_addr = base + scaled4;
			next_addr_valid = 1'b1;
		end
		`OAG_M_IDX: begin
			next_addr = src_val + r0_val;
			next_addr_valid = 1'b1;
		end
		`OAG_M_GBDISP: begin
			next_addr = global_base_pointer + scaled8;
			next_addr_valid = 1'b1;
		end
		`OAG_M_GBIDX: begin
			next_addr = global_base_pointer + r0_val;
			next_addr_valid = 1'b1;
		end
		`OAG_M_PCDISP: begin
			// Longword literal pools sit on aligned words
			if (size == `OAG_SZ_LONG) begin
				next_addr = (pc & `OAG_LONG_PC_MASK) + scaled8;
			end else begin
				next_addr = pc + {23'h00_0000, disp8, 1'h0};
			end
			next_addr_valid = 1'b1;
		end
		`OAG_M_BR8: begin
			// Branch displacements are signed and count half-words
			next_target = pc + {{23{disp8[7]}}, disp8, 1'h0};
			next_branch_valid = 1'b1;
		end
		`OAG_M_BR12: begin
			next_target = pc + {{19{disp12[11]}}, disp12, 1'h0};
			next_branch_valid = 1'b1;
		end
		`OAG_M_BRREG: begin
			next_target = pc + src_val;
			next_branch_valid = 1'b1;
		end
		`OAG_M_MAC: begin
			// Two source streams, both stepped; nnnn acts as a source
			next_addr = src_val;
			next_addr_valid = 1'b1;
			next_addr2_valid = 1'b1;
			next_wb_en = 1'b1;
			next_wb_reg = src_reg;
			next_wb_value = src_val + step;
			next_wb2_en = 1'b1;
			next_accum = 1'b1;
		end
		default: begin
			next_operand = 32'h0000_0000;
		end
		endcase
	end

	// Alignment check for word and longword accesses, both addresses
	// Byte accesses never fault; branch targets and direct operands are
	// not data addresses, so they never raise the error strobe
	always @* begin
		next_misalign = 1'b0;
		if (next_addr_valid) begin
			if (size == `OAG_SZ_WORD) begin
				next_misalign = next_addr[0] |
					(next_addr2_valid & dst_val[0]);
			end else if (size == `OAG_SZ_LONG) begin
				next_misalign = (|next_addr[1:0]) |
					(next_addr2_valid & (|dst_val[1:0]));
			end
		end
	end

	// ------------------------------------------------------------------
	// Result registers; one cycle from request to answer
	// ------------------------------------------------------------------
	// Strobes stand for one cycle per request, so idle cycles are no-ops
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			out_valid <= 1'b0;
			addr_valid <= 1'b0;
			addr2_valid <= 1'b0;
			branch_valid <= 1'b0;
			wb_en <= 1'b0;
			wb2_en <= 1'b0;
			accum_write <= 1'b0;
			addr_error <= 1'b0;
		end else begin
			out_valid <= req_valid;
			addr_valid <= req_valid & next_addr_valid;
			addr2_valid <= req_valid & next_addr2_valid;
			branch_valid <= req_valid & next_branch_valid;
			wb_en <= req_valid & next_wb_en;
			wb2_en <= req_valid & next_wb2_en;
			accum_write <= req_valid & next_accum;
			addr_error <= req_valid & next_misalign;
		end
	end

	// Data holds its last value between requests; the strobes say when it
	// is fresh, and holding it spares the load/store side idle toggling
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			addr <= 32'h0000_0000;
			addr2 <= 32'h0000_0000;
			operand <= 32'h0000_0000;
			imm_value <= 32'h0000_0000;
			branch_target <= 32'h0000_0000;
			wb_reg <= 4'h0;
			wb_value <= 32'h0000_0000;
			wb2_reg <= 4'h0;
			wb2_value <= 32'h0000_0000;
		end else if (req_valid) begin
			addr <= next_addr;
			addr2 <= dst_val;
			operand <= next_operand;
			imm_value <= imm_ext;
			branch_target <= next_target;
			wb_reg <= next_wb_reg;
			wb_value <= next_wb_value;
			wb2_reg <= dst_reg;
			wb2_value <= dst_val + step;
		end
	end

endmodule

// [sim/oag_top_props.sv]
// Port-level checks of the operand address generator.
// Assumes binding to oag_top, one cycle from request to answer.
`timescale 1ns/10ps
`include "oag_defines.vh"

module oag_top_props (
	// Clock, reset and request
	input wire ref_clk,
	input wire resetn,
	input wire req_valid,
	input wire [15:0] instr,
	input wire [3:0] mode,
	input wire [1:0] size,
	// Register contents
	input wire [31:0] src_val,
	input wire [31:0] dst_val,
	input wire [31:0] r0_val,
	input wire [31:0] global_base_pointer,
	input wire [31:0] pc,
	// Results
	input wire addr_valid,
	input wire [31:0] addr,
	input wire [31:0] operand,
	input wire [31:0] branch_target,
	input wire wb_en,
	input wire [31:0] wb_value,
	input wire addr_error
);
	// -----------------------------------------------------------------
	// Helpers; size 3 is left out, its step is not byte-like here
	// -----------------------------------------------------------------
	wire [31:0] step = 32'h0000_0001 << size;
	wire [31:0] br8_off = {{23{instr[7]}}, instr[7:0], 1'b0};
	wire go = req_valid && (size != 2'h3);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	a_direct_operand: assert property (
		go && mode == `OAG_M_DIRECT |=> operand == $past(src_val)
		&& !addr_valid) else $error("direct operand wrong");
	a_postinc_step: assert property (
		go && mode == `OAG_M_POSTINC |=> wb_en && addr == $past(src_val)
		&& wb_value == $past(src_val) + $past(step))
		else $error("post-increment wrong");
	a_predec_step: assert property (
		go && mode == `OAG_M_PREDEC |=> addr == wb_value
		&& addr == $past(dst_val) - $past(step))
		else $error("pre-decrement wrong");
	a_gb_index: assert property (
		go && mode == `OAG_M_GBIDX |=> addr_valid
		&& addr == $past(global_base_pointer) + $past(r0_val))
		else $error("global index wrong");
	a_br8_target: assert property (
		go && mode == `OAG_M_BR8 |=>
		branch_target == $past(pc) + $past(br8_off))
		else $error("short branch wrong");
	a_brreg_target: assert property (
		go && mode == `OAG_M_BRREG |=>
		branch_target == $past(pc) + $past(src_val))
		else $error("register branch wrong");
	a_word_align: assert property (
		go && mode == `OAG_M_IND && size == `OAG_SZ_WORD |=>
		addr_error == $past(src_val[0]) && addr == $past(src_val))
		else $error("word alignment wrong");
	a_idle_quiet: assert property (
		!req_valid |=> !addr_valid && !wb_en && !addr_error)
		else $error("pulse without request");
	c_mac: cover property (go && mode == `OAG_M_MAC);
	c_err: cover property (addr_error);
	c_wb: cover property (wb_en);
endmodule

bind oag_top oag_top_props chk_u (.ref_clk(ref_clk), .resetn(resetn),
	.req_valid(req_valid), .instr(instr), .mode(mode), .size(size),
	.src_val(src_val), .dst_val(dst_val), .r0_val(r0_val), .pc(pc),
	.global_base_pointer(global_base_pointer), .addr_valid(addr_valid),
	.addr(addr), .operand(operand), .branch_target(branch_target),
	.wb_en(wb_en), .wb_value(wb_value), .addr_error(addr_error));

// [sim/oag_regfile_model.sv]
// Register read port of the pipeline feeding the address generator.
// Assumes the decoder's register numbers settle within the cycle.
`timescale 1ns/10ps

module oag_regfile_model (
	// Base value and register numbers
	input wire [31:0] base,
	input wire [3:0] src_reg,
	input wire [3:0] dst_reg,
	// Register contents
	output wire [31:0] src_val,
	output wire [31:0] dst_val,
	output wire [31:0] r0_val
);
	// Each register differs, so a wrong field pick shows up
	assign src_val = base + {24'h00_0000, src_reg, 4'h0};
	assign dst_val = base + {24'h00_0000, dst_reg, 4'h0};
	assign r0_val = base;
endmodule

// [sim/oag_top_tb.sv]
// Self-checking bench of the operand address generator.
// Assumes the register model answers reads combinationally.
`timescale 1ns/10ps
`include "oag_defines.vh"

module oag_top_tb;
	reg ref_clk = 1'b0;
	reg resetn = 1'b0;
	reg req_valid = 1'b0;
	reg [15:0] instr = 16'h0000;
	reg [3:0] mode = 4'h0;
	reg [2:0] fmt = 3'h0;
	reg [1:0] size = 2'h0;
	reg [1:0] imm_kind = 2'h0;
	reg [31:0] global_base_pointer = 32'h0000_0000;
	reg [31:0] pc = 32'h0000_0000;
	reg [31:0] base = 32'h0000_0000;
	wire [31:0] src_val, dst_val, r0_val, addr, addr2, operand, imm_value;
	wire [31:0] branch_target, wb_value, wb2_value;
	wire [3:0] dst_reg, src_reg, wb_reg, wb2_reg;
	wire out_valid, addr_valid, addr2_valid, branch_valid, wb_en, wb2_en;
	wire accum_write, addr_error;
	integer fail_count = 0;
	integer checks_done = 0;
	integer s;
	reg [31:0] exp_imm;

	// -----------------------------------------------------------------
	// Clock, design and register model
	// -----------------------------------------------------------------
	always #50 ref_clk = ~ref_clk;
	oag_top dut_u (.ref_clk(ref_clk), .resetn(resetn),
		.req_valid(req_valid), .instr(instr), .mode(mode), .fmt(fmt),
		.size(size), .imm_kind(imm_kind), .src_val(src_val),
		.dst_val(dst_val), .r0_val(r0_val), .pc(pc),
		.global_base_pointer(global_base_pointer), .dst_reg(dst_reg),
		.src_reg(src_reg), .out_valid(out_valid), .addr_valid(addr_valid),
		.addr(addr), .addr2(addr2), .addr2_valid(addr2_valid),
		.operand(operand), .imm_value(imm_value), .wb_en(wb_en),
		.branch_target(branch_target), .branch_valid(branch_valid),
		.wb_reg(wb_reg), .wb_value(wb_value), .wb2_en(wb2_en),
		.wb2_reg(wb2_reg), .wb2_value(wb2_value),
		.accum_write(accum_write), .addr_error(addr_error));
	oag_regfile_model rf_u (.base(base), .src_reg(src_reg),
		.dst_reg(dst_reg), .src_val(src_val), .dst_val(dst_val),
		.r0_val(r0_val));

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	function [31:0] rv(input [3:0] r);
		rv = base + {24'h00_0000, r, 4'h0};
	endfunction
	// Wide enough for two words, or a strobe, a register number and one word
	task chk(input [63:0] seen, input [63:0] exp);
		begin
			checks_done = checks_done + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("unexpected at %0t seen %h exp %h", $time, seen, exp);
			end
		end
	endtask
	// One request, checked just after the edge that answers it
	task rq(input [15:0] i, input [3:0] m, input [2:0] f,
		input [1:0] z, input [1:0] k);
		begin
			@(posedge ref_clk);
			instr <= i;
			mode <= m;
			fmt <= f;
			size <= z;
			imm_kind <= k;
			req_valid <= 1'b1;
			@(posedge ref_clk);
			req_valid <= 1'b0;
			#1;
		end
	endtask
	task setv(input [31:0] b, input [31:0] p);
		begin
			@(posedge ref_clk);
			base <= b;
			pc <= p;
			global_base_pointer <= 32'h0000_4000;
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", checks_done, fail_count);
			if (fail_count == 0 && checks_done > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task s_basic;
		begin
			rq(16'h6AB3, `OAG_M_DIRECT, `OAG_F_NM, `OAG_SZ_LONG, 2'h0);
			chk({dst_reg, src_reg}, 8'hAB);
			chk({addr_valid, operand}, {1'b0, rv(4'hB)});
			rq(16'h6440, `OAG_M_IND, `OAG_F_NM, `OAG_SZ_LONG, 2'h0);
			chk(addr, rv(4'h4));
			rq(16'h0770, `OAG_M_IDX, `OAG_F_NM, `OAG_SZ_LONG, 2'h0);
			chk(addr, rv(4'h7) + rv(4'h0));
			rq(16'h0770, `OAG_M_GBIDX, `OAG_F_NM, `OAG_SZ_LONG, 2'h0);
			chk(addr, 32'h0000_4000 + rv(4'h0));
		end
	endtask
	task s_sized;
		begin
			for (s = 0; s < 3; s = s + 1) begin
				rq(16'h6550, `OAG_M_POSTINC, `OAG_F_NM, s[1:0], 2'h0);
				chk(addr, rv(4'h5));
				chk({wb_en, wb_reg, wb_value}, {5'h15, rv(4'h5) + (1 << s)});
				rq(16'h6550, `OAG_M_PREDEC, `OAG_F_NM, s[1:0], 2'h0);
				chk({addr, wb_value}, {2{rv(4'h5) - (1 << s)}});
				rq(16'h8537, `OAG_M_DISP4, `OAG_F_MD, s[1:0], 2'h0);
				chk({src_reg, dst_reg}, 8'h30);
				chk(addr, rv(4'h3) + (7 << s));
				rq(16'h8537, `OAG_M_DISP4, `OAG_F_ND4, s[1:0], 2'h0);
				chk({src_reg, dst_reg}, 8'h03);
				chk(addr, rv(4'h3) + (7 << s));
				rq(16'hC4F3, `OAG_M_GBDISP, `OAG_F_NI, s[1:0], 2'h0);
				chk(addr, 32'h0000_4000 + (32'hF3 << s));
				rq(16'hE49C, `OAG_M_DIRECT, `OAG_F_NI, 2'h0, s[1:0]);
				chk(dst_reg, 4'h4);
				// Logical, arithmetic and trap extension of the same byte
				case (s)
				0: exp_imm = 32'h0000_009C;
				1: exp_imm = 32'hFFFF_FF9C;
				default: exp_imm = 32'h0000_0270;
				endcase
				chk(imm_value, exp_imm);
			end
		end
	endtask
	task s_mac;
		begin
			rq(16'h4FBF, `OAG_M_MAC, `OAG_F_NM, `OAG_SZ_LONG, 2'h0);
			chk({addr, addr2}, {rv(4'hB), rv(4'hF)});
			chk({wb_value, wb2_value}, {rv(4'hB) + 4, rv(4'hF) + 4});
			chk({accum_write, wb_en, wb2_en, wb_reg, wb2_reg}, 11'h7BF);
			chk({out_valid, addr_valid, addr2_valid}, 3'h7);
			// Strobes stand for one cycle only
			@(posedge ref_clk);
			#1;
			chk({out_valid, addr_valid, addr2_valid}, 3'h0);
			chk({wb_en, wb2_en, accum_write}, 3'h0);
		end
	endtask
	task s_pc;
		begin
			setv(32'h0000_2000, 32'h0000_0006);
			rq(16'h91F3, `OAG_M_PCDISP, `OAG_F_NI, `OAG_SZ_WORD, 2'h0);
			chk(addr, 32'h0000_01EC);
			rq(16'hD1F3, `OAG_M_PCDISP, `OAG_F_NI, `OAG_SZ_LONG, 2'h0);
			chk(addr, 32'h0000_03D0);
			rq(16'h8B80, `OAG_M_BR8, `OAG_F_NI, 2'h0, 2'h0);
			chk({out_valid, branch_valid}, 2'h3);
			chk(branch_target, 32'hFFFF_FF06);
			rq(16'hA801, `OAG_M_BR12, `OAG_F_NI, 2'h0, 2'h0);
			chk(branch_target, 32'hFFFF_F008);
			rq(16'h0A23, `OAG_M_BRREG, `OAG_F_M, 2'h0, 2'h0);
			chk(src_reg, 4'hA);
			chk(branch_target, 32'h0000_0006 + rv(4'hA));
		end
	endtask
	task s_err;
		begin
			setv(32'h0000_1001, 32'h0000_0006);
			rq(16'h6110, `OAG_M_IND, `OAG_F_NM, `OAG_SZ_WORD, 2'h0);
			chk(addr_error, 1'b1);
			rq(16'h6110, `OAG_M_IND, `OAG_F_NM, `OAG_SZ_BYTE, 2'h0);
			chk(addr_error, 1'b0);
			setv(32'h0000_1002, 32'h0000_0006);
			rq(16'h6110, `OAG_M_IND, `OAG_F_NM, `OAG_SZ_WORD, 2'h0);
			chk(addr_error, 1'b0);
			rq(16'h6110, `OAG_M_IND, `OAG_F_NM, `OAG_SZ_LONG, 2'h0);
			chk(addr_error, 1'b1);
			setv(32'hFFFF_FFFC, 32'h0000_0006);
			rq(16'h6000, `OAG_M_POSTINC, `OAG_F_NM, `OAG_SZ_LONG, 2'h0);
			chk(wb_value, 32'h0000_0000);
		end
	endtask

	// -----------------------------------------------------------------
	// Main sequence and watchdog
	// -----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		setv(32'h0000_2000, 32'h0000_0006);
		s_basic;
		s_sized;
		s_mac;
		s_pc;
		s_err;
		stop_test;
	end
	initial begin
		#100_000;
		fail_count = fail_count + 1;
		stop_test;
	end
endmodule
